// ### src/fsc_regs.svh
// Constants of the serial command slave: opcodes, memory map, APB offsets, reset values.
// Assumes inclusion from the top module and from the bench by bare name.
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH

// Serial opcodes.
`define FSC_OP_READ        8'h03
`define FSC_OP_WRITE       8'h02
`define FSC_OP_RD_PROTECT  8'h09
`define FSC_OP_WR_PROTECT  8'h08
`define FSC_OP_FETCH_UID   8'h0c

// Serial field lengths, as last-bit indices of each phase.
`define FSC_OP_LAST        6'd7
`define FSC_WORD_LAST      6'd15
`define FSC_UID_LAST       6'd63

// Serial address map, 13 significant address bits.
`define FSC_USER_TOP       13'h0fff
`define FSC_LOCK_BASE      13'h1000
`define FSC_LOCK_TOP       13'h103f
`define FSC_LOCK_WRAP      13'h0100
`define FSC_ADDR_ZERO      13'h0000

// Protection word field positions.
`define FSC_PROT_BLK_HI    15
`define FSC_PROT_BLK_LO    8
`define FSC_PROT_FLAG      7

// APB register byte offsets.
`define FSC_CTRL_OFS       12'h000
`define FSC_STATUS_OFS     12'h004
`define FSC_UID_LO_OFS     12'h008
`define FSC_UID_HI_OFS     12'h00c
`define FSC_CMDCNT_OFS     12'h010

// Control field position and reset values.
`define FSC_CTRL_EN_BIT    0
`define FSC_CTRL_RST       1'b1
// Arbitrary neutral identifier value.
`define FSC_UID_RST        64'h0123_4567_89ab_cdef

`endif

// ### src/fsc_pkg.sv
// Types of the serial command slave: state encoding and the packed state record.
// Assumes fsc_regs.svh is reachable on the include path.
package fsc_pkg;

   typedef enum logic [2:0] {
      ST_OP    = 3'b000,
      ST_ADDR  = 3'b001,
      ST_RDATA = 3'b011,
      ST_WDATA = 3'b010,
      ST_PROT  = 3'b110,
      ST_UID   = 3'b111,
      ST_IGN   = 3'b101
   } fsc_state_t;

   typedef struct packed {
      logic         cs_m;
      logic         cs_s;
      logic         sck_m;
      logic         sck_s;
      logic         sck_d;
      logic         si_m;
      logic         si_s;
      fsc_state_t   st;
      logic [5:0]   cnt;
      logic [15:0]  sh;
      logic [7:0]   op;
      logic [12:0]  addr;
      logic         in_lock;
      logic [255:0] rlock;
      logic [255:0] wlock;
      logic         so;
      logic         so_oe;
      logic         en;
      logic [63:0]  unique_identifier;
      logic [7:0]   last_op;
      logic [15:0]  cmd_cnt;
      logic [31:0]  prdata;
   } fsc_state_rec_t;

endpackage : fsc_pkg

// ### src/fsc_top.sv
// Serial command slave for a memory tag: opcode decode, word read and write,
// per-block protection and identifier readout, plus an APB register slave.
// Assumes SELECT_BAR, SCK and SI come asynchronously from an external master
// whose clock is far slower than CLOCK, so that every edge is seen.
`timescale 1ns/1ps
`include "fsc_regs.svh"

// Operation
// - Only five opcodes are accepted; any other opcode does nothing.
// - Read is 03h, write is 02h, both move 16-bit words.
// - Read protect 09h, write protect 08h, identifier fetch 0Ch.
// - Select released before the full opcode abandons the command.
// - Read and write take a 16-bit address; upper 3 bits ignored.
// - Read data leaves on falling clock edges; input ignored meanwhile.
// - Read address steps every 16 clocks and wraps to 0000h.
// - A read started in the protection region wraps to 100h.
// - Select rising ends any read.
// - Read-protected blocks read as 0000h.
// - Read serves both user area and protection-status area.
// - Write takes 16-bit words, steps every 16 clocks, wraps to zero.
// - Select rising ends any write.
// - Writes reach only the user area; write-protected blocks are untouched.
// - Read protect word: block in bits 15..8, bit 7 forbids reads.
// - Write protect word: same layout, bit 7 forbids writes.
// - Protection acts on blocks 00h..FFh and never drives the output.
// - Identifier fetch shifts 64 bits out, bit 63 first, on falls.
// - Clocks beyond 64 keep the last identifier bit on the output.
module fsc_top #(
   parameter int WORDS = 4096
) (
   // Clock and reset.
   input  wire logic        CLOCK,
   input  wire logic        SRST,
   // Serial link.
   input  wire logic        SELECT_BAR,
   input  wire logic        SCK,
   input  wire logic        SI,
   output logic             SO,
   output logic             SO_OE,
   // APB slave.
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR
);

   fsc_pkg::fsc_state_rec_t s_ff;
   fsc_pkg::fsc_state_rec_t nxt_s;

   logic [15:0] mem [WORDS];
   logic        mem_we;
   logic [11:0] mem_wa;
   logic [15:0] mem_wd;
   logic        sck_rise;
   logic        sck_fall;
   logic [15:0] rd_word;
   logic [15:0] in_word;
   logic        apb_wr;

   // Word seen by the serial reader at a given address.
   function automatic logic [15:0] fetch_word(input logic [12:0] a,
                                              input logic [15:0] user_word,
                                              input logic [255:0] rl,
                                              input logic [255:0] wl);
      logic [5:0] k;
      k = a[5:0];
      if (a <= `FSC_USER_TOP) begin
         fetch_word = rl[a[11:4]] ? 16'h0000 : user_word;
      end else if (a <= `FSC_LOCK_TOP && !k[5] && !k[4]) begin
         fetch_word = rl[{k[3:0], 4'h0} +: 16];
      end else if (a <= `FSC_LOCK_TOP && !k[5]) begin
         fetch_word = wl[{k[3:0], 4'h0} +: 16];
      end else begin
         fetch_word = 16'h0000;
      end
   endfunction : fetch_word

   // Address after one word, with the wrap point chosen by where the read began.
   function automatic logic [12:0] step_addr(input logic [12:0] a, input logic in_lock);
      if (in_lock && a == `FSC_LOCK_TOP) begin
         step_addr = `FSC_LOCK_WRAP;
      end else if (a == `FSC_USER_TOP) begin
         step_addr = `FSC_ADDR_ZERO;
      end else begin
         step_addr = a + 13'h0001;
      end
   endfunction : step_addr

   function automatic logic reg_mapped(input logic [11:0] a);
      reg_mapped = (a == `FSC_CTRL_OFS) || (a == `FSC_STATUS_OFS) ||
                   (a == `FSC_UID_LO_OFS) || (a == `FSC_UID_HI_OFS) ||
                   (a == `FSC_CMDCNT_OFS);
   endfunction : reg_mapped

   assign sck_rise = s_ff.sck_s & ~s_ff.sck_d;
   assign sck_fall = ~s_ff.sck_s & s_ff.sck_d;
   assign rd_word  = fetch_word(s_ff.addr, mem[s_ff.addr[11:0]], s_ff.rlock, s_ff.wlock);
   assign in_word  = {s_ff.sh[14:0], s_ff.si_s};
   assign apb_wr   = PSEL & PENABLE & PWRITE;

   always_comb begin
      nxt_s  = s_ff;
      mem_we = 1'b0;
      mem_wa = 12'h000;
      mem_wd = 16'h0000;

      // Two-stage synchronisers; the second stage is looked at, plus a delayed copy of SCK for edge detection.
      nxt_s.cs_m  = SELECT_BAR;
      nxt_s.cs_s  = s_ff.cs_m;
      nxt_s.sck_m = SCK;
      nxt_s.sck_s = s_ff.sck_m;
      nxt_s.sck_d = s_ff.sck_s;
      nxt_s.si_m  = SI;
      nxt_s.si_s  = s_ff.si_m;

      if (s_ff.cs_s || !s_ff.en) begin
         // Select high drops whatever was under way, even half an opcode.
         nxt_s.st    = fsc_pkg::ST_OP;
         nxt_s.cnt   = 6'd0;
         nxt_s.so_oe = 1'b0;
         nxt_s.so    = 1'b0;
      end else if (sck_rise) begin
         nxt_s.sh  = in_word;
         nxt_s.cnt = s_ff.cnt + 6'd1;
         case (s_ff.st)
            fsc_pkg::ST_OP: begin
               if (s_ff.cnt == `FSC_OP_LAST) begin
                  nxt_s.cnt = 6'd0;
                  nxt_s.op  = in_word[7:0];
                  case (in_word[7:0])
                     `FSC_OP_READ, `FSC_OP_WRITE: begin
                        nxt_s.st = fsc_pkg::ST_ADDR;
                     end
                     `FSC_OP_RD_PROTECT, `FSC_OP_WR_PROTECT: begin
                        nxt_s.st = fsc_pkg::ST_PROT;
                     end
                     `FSC_OP_FETCH_UID: begin
                        nxt_s.st = fsc_pkg::ST_UID;
                     end
                     default: begin
                        nxt_s.st = fsc_pkg::ST_IGN;
                     end
                  endcase
                  if (in_word[7:0] == `FSC_OP_READ || in_word[7:0] == `FSC_OP_WRITE ||
                      in_word[7:0] == `FSC_OP_RD_PROTECT ||
                      in_word[7:0] == `FSC_OP_WR_PROTECT ||
                      in_word[7:0] == `FSC_OP_FETCH_UID) begin
                     nxt_s.last_op = in_word[7:0];
                     nxt_s.cmd_cnt = s_ff.cmd_cnt + 16'h0001;
                  end
               end
            end
            fsc_pkg::ST_ADDR: begin
               if (s_ff.cnt == `FSC_WORD_LAST) begin
                  nxt_s.cnt     = 6'd0;
                  nxt_s.addr    = in_word[12:0];
                  nxt_s.in_lock = (in_word[12:0] >= `FSC_LOCK_BASE) &&
                                  (in_word[12:0] <= `FSC_LOCK_TOP);
                  nxt_s.st      = (s_ff.op == `FSC_OP_READ) ? fsc_pkg::ST_RDATA
                                                            : fsc_pkg::ST_WDATA;
               end
            end
            fsc_pkg::ST_WDATA: begin
               if (s_ff.cnt == `FSC_WORD_LAST) begin
                  nxt_s.cnt  = 6'd0;
                  nxt_s.addr = step_addr(s_ff.addr, 1'b0);
                  if (s_ff.addr <= `FSC_USER_TOP && !s_ff.wlock[s_ff.addr[11:4]]) begin
                     mem_we = 1'b1;
                     mem_wa = s_ff.addr[11:0];
                     mem_wd = in_word;
                  end
               end
            end
            fsc_pkg::ST_PROT: begin
               if (s_ff.cnt == `FSC_WORD_LAST) begin
                  nxt_s.cnt = 6'd0;
                  nxt_s.st  = fsc_pkg::ST_IGN;
                  if (s_ff.op == `FSC_OP_RD_PROTECT) begin
                     nxt_s.rlock[in_word[`FSC_PROT_BLK_HI:`FSC_PROT_BLK_LO]] =
                        in_word[`FSC_PROT_FLAG];
                  end else begin
                     nxt_s.wlock[in_word[`FSC_PROT_BLK_HI:`FSC_PROT_BLK_LO]] =
                        in_word[`FSC_PROT_FLAG];
                  end
               end
            end
            fsc_pkg::ST_RDATA, fsc_pkg::ST_UID: begin
               // Input is meaningless while the device talks.
               nxt_s.cnt = s_ff.cnt;
            end
            fsc_pkg::ST_IGN: begin
               nxt_s.cnt = 6'd0;
            end
            default: begin
               nxt_s.st  = fsc_pkg::ST_IGN;
               nxt_s.cnt = 6'd0;
            end
         endcase
      end else if (sck_fall) begin
         case (s_ff.st)
            fsc_pkg::ST_RDATA: begin
               nxt_s.so_oe = 1'b1;
               nxt_s.so    = rd_word[4'hf - s_ff.cnt[3:0]];
               if (s_ff.cnt == `FSC_WORD_LAST) begin
                  nxt_s.cnt  = 6'd0;
                  nxt_s.addr = step_addr(s_ff.addr, s_ff.in_lock);
               end else begin
                  nxt_s.cnt = s_ff.cnt + 6'd1;
               end
            end
            fsc_pkg::ST_UID: begin
               nxt_s.so_oe = 1'b1;
               nxt_s.so    = s_ff.unique_identifier[6'h3f - s_ff.cnt];
               if (s_ff.cnt != `FSC_UID_LAST) begin
                  nxt_s.cnt = s_ff.cnt + 6'd1;
               end
            end
            default: begin
               nxt_s.so_oe = 1'b0;
            end
         endcase
      end

      // APB: read data is latched in the setup phase, writes land in the access phase.
      if (PSEL && !PENABLE) begin
         case (PADDR)
            `FSC_CTRL_OFS:   nxt_s.prdata = {31'h0000_0000, s_ff.en};
            `FSC_STATUS_OFS: nxt_s.prdata = {16'h0000, s_ff.last_op, 3'h0,
                                             ~s_ff.cs_s, s_ff.so_oe, s_ff.st};
            `FSC_UID_LO_OFS: nxt_s.prdata = s_ff.unique_identifier[31:0];
            `FSC_UID_HI_OFS: nxt_s.prdata = s_ff.unique_identifier[63:32];
            `FSC_CMDCNT_OFS: nxt_s.prdata = {16'h0000, s_ff.cmd_cnt};
            default:         nxt_s.prdata = 32'h0000_0000;
         endcase
      end
      if (apb_wr) begin
         case (PADDR)
            `FSC_CTRL_OFS:   nxt_s.en         = PWDATA[`FSC_CTRL_EN_BIT];
            `FSC_UID_LO_OFS: nxt_s.unique_identifier[31:0]  = PWDATA;
            `FSC_UID_HI_OFS: nxt_s.unique_identifier[63:32] = PWDATA;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         s_ff         <= '0;
         s_ff.cs_m    <= 1'b1;
         s_ff.cs_s    <= 1'b1;
         s_ff.st      <= fsc_pkg::ST_OP;
         s_ff.en      <= `FSC_CTRL_RST;
         s_ff.unique_identifier     <= `FSC_UID_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // The array has no reset; its contents are whatever was last written.
   always_ff @(posedge CLOCK) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign SO      = s_ff.so;
   assign SO_OE   = s_ff.so_oe;
   assign PRDATA  = s_ff.prdata;
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~reg_mapped(PADDR);

endmodule : fsc_top

// ### sim/fsc_checker.sv
// Pin-level checks on the serial command slave and its APB port.
// Assumes the link clock is far slower than CLOCK.
`timescale 1ns/1ps
module fsc_checker (
   // Clock and reset.
   input wire logic        CLOCK,
   input wire logic        SRST,
   // Serial link.
   input wire logic        SELECT_BAR,
   input wire logic        SCK,
   input wire logic        SO,
   input wire logic        SO_OE,
   // APB.
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SRST);
   sequence s_idle; SELECT_BAR [*5]; endsequence
   sequence s_busy; (!SELECT_BAR) [*4]; endsequence
   sequence s_access; PSEL && PENABLE; endsequence
   property p_oe_idle; s_idle |-> !SO_OE; endproperty
   property p_oe_rise; $rose(SO_OE) |-> !SELECT_BAR && !SCK; endproperty
   property p_oe_drop; $rose(SELECT_BAR) |-> ##[1:4] !SO_OE; endproperty
   property p_oe_keep; s_busy ##0 SO_OE |=> SO_OE; endproperty
   property p_so_fall; SO_OE && $past(SO_OE) && $changed(SO) |-> !SCK; endproperty
   property p_ready; PREADY; endproperty
   property p_err_map;
      PSEL && PENABLE && PADDR[1:0] == 2'b00 |-> PSLVERR == (PADDR > 12'h010);
   endproperty
   property p_err_only; PSLVERR |-> PSEL && PENABLE; endproperty
   property p_rd_hold; s_access |=> $stable(PRDATA); endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("output driven while deselected");
   a_oe_rise: assert property (p_oe_rise)
      else $error("output enable rose off a falling clock");
   a_oe_drop: assert property (p_oe_drop)
      else $error("output enable kept after deselect");
   a_oe_keep: assert property (p_oe_keep)
      else $error("output enable dropped inside a frame");
   a_so_fall: assert property (p_so_fall)
      else $error("serial output changed with clock high");
   a_ready: assert property (p_ready)
      else $error("ready low");
   a_err_map: assert property (p_err_map)
      else $error("error response wrong for address");
   a_err_only: assert property (p_err_only)
      else $error("error response outside access");
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved after access");
endmodule : fsc_checker

bind fsc_top fsc_checker u_chk (.CLOCK(CLOCK), .SRST(SRST), .SELECT_BAR(SELECT_BAR),
   .SCK(SCK), .SO(SO), .SO_OE(SO_OE), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

// ### sim/fsc_spi_master.sv
// Model of the external serial controller: runs one framed transfer at a time.
// Assumes a 125 ns link clock that idles low between frames.
`timescale 1ns/1ps
module fsc_spi_master (
   // Serial link.
   output logic      select_bar,
   output logic      sck,
   output logic      si,
   input wire logic  so,
   input wire logic  so_oe
);
   initial begin
      select_bar = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // A gap stretches the low phase to model a slow controller.
   task automatic frame(input logic [127:0] tx, input int nbits, input realtime gap,
                        output logic [127:0] rx, output logic oe);
      rx = '0;
      oe = 1'b0;
      select_bar = 1'b0;
      #62.5;
      for (int i = nbits - 1; i >= 0; i--) begin
         si = tx[i];
         #(62.5 + gap);
         sck = 1'b1;
         // A released output reads as the inverse of its last value, so stale data cannot pass.
         rx = {rx[126:0], so_oe ? so : ~so};
         oe = oe | so_oe;
         #62.5;
         sck = 1'b0;
      end
      #62.5;
      select_bar = 1'b1;
      si = ~si;
      #250;
   endtask : frame
endmodule : fsc_spi_master

// ### sim/fsc_top_bench.sv
// Self-checking bench for the serial command slave and its APB registers.
// Assumes the serial master model and the bound checker.
`timescale 1ns/1ps
`include "fsc_regs.svh"
module fsc_top_bench;
   logic [11:0]  paddr;
   logic [31:0]  pwdata;
   logic [31:0]  prdata;
   logic [127:0] rx;
   logic         clock;
   logic         srst;
   logic         psel;
   logic         penable;
   logic         pwrite;
   logic         pready;
   logic         pslverr;
   logic         select_bar;
   logic         sck;
   logic         si;
   logic         so;
   logic         so_oe;
   logic         oe;
   int           n_errors = 0;
   int           check_count = 0;
   int           cycles = 0;
   fsc_top dut (.CLOCK(clock), .SRST(srst), .SELECT_BAR(select_bar), .SCK(sck), .SI(si),
      .SO(so), .SO_OE(so_oe), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
   fsc_spi_master m (.select_bar(select_bar), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
   task automatic test_done;
      $display("checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb
   task automatic sread(input logic [15:0] a, input int nw, output logic [47:0] d);
      m.frame({8'h03, a, 48'h5a5a_c3c3_0f0f} >> (16 * (3 - nw)), 24 + 16 * nw, 0.0, rx, oe);
      d = rx[47:0];
   endtask : sread
   task automatic swrite(input logic [15:0] a, input logic [47:0] d, input int nw);
      m.frame({8'h02, a, d} >> (16 * (3 - nw)), 24 + 16 * nw, 0.0, rx, oe);
   endtask : swrite
   task automatic prot(input logic [7:0] op, input logic [15:0] w);
      m.frame({op, w}, 24, 0.0, rx, oe);
      chk("protect drive", oe, 1'b0);
   endtask : prot
   task automatic t_regs;
      logic [31:0] r;
      logic        e;
      logic [47:0] d;
      apb(1'b0, `FSC_CTRL_OFS, 32'h0, r, e);
      chk("ctrl", r, 32'h1);
      chk("ctrl error", e, 1'b0);
      apb(1'b1, `FSC_CTRL_OFS, 32'h0, r, e);
      sread(16'h0ffe, 1, d);
      chk("disabled drive", oe, 1'b0);
      apb(1'b1, `FSC_CTRL_OFS, 32'h1, r, e);
      apb(1'b0, `FSC_UID_HI_OFS, 32'h0, r, e);
      chk("uid hi", r, 32'h0123_4567);
      apb(1'b1, `FSC_UID_LO_OFS, 32'h1357_9bdf, r, e);
      apb(1'b1, `FSC_UID_HI_OFS, 32'h2468_ace0, r, e);
      apb(1'b0, `FSC_UID_LO_OFS, 32'h0, r, e);
      chk("uid lo", r, 32'h1357_9bdf);
      apb(1'b0, 12'h020, 32'h0, r, e);
      chk("unmapped", {e, r}, 33'h1_0000_0000);
   endtask : t_regs
   task automatic t_rw;
      logic [47:0] d;
      swrite(16'heffe, 48'hc001_0ffb_7e57, 3);
      sread(16'h0ffe, 3, d);
      chk("wrapped words", d, 48'hc001_0ffb_7e57);
   endtask : t_rw
   task automatic t_bad;
      logic [47:0] d;
      m.frame({8'h04, 16'h0ffe, 16'hdead}, 40, 0.0, rx, oe);
      chk("bad opcode drive", oe, 1'b0);
      m.frame(128'h01, 7, 0.0, rx, oe);
      sread(16'h0ffe, 1, d);
      chk("after ignored", d[15:0], 16'hc001);
   endtask : t_bad
   task automatic t_prot;
      logic [47:0] d;
      prot(8'h08, 16'hff80);
      swrite(16'h0fff, 48'hbad0_0000_0000, 1);
      sread(16'h0fff, 1, d);
      chk("write locked", d[15:0], 16'h0ffb);
      sread(16'h101f, 1, d);
      chk("wlock status", d[15:0], 16'h8000);
      prot(8'h09, 16'h0080);
      sread(16'h0000, 1, d);
      chk("read locked", d[15:0], 16'h0000);
      sread(16'h1000, 1, d);
      chk("rlock status", d[15:0], 16'h0001);
      swrite(16'h0100, 48'h0e0e_0000_0000, 1);
      sread(16'h103f, 2, d);
      chk("status wrap", d[31:0], 32'h0000_0e0e);
      prot(8'h09, 16'h007f);
      prot(8'h08, 16'hff7f);
      sread(16'h0000, 1, d);
      chk("read unlocked", d[15:0], 16'h7e57);
      swrite(16'h0fff, 48'hbad0_0000_0000, 1);
      sread(16'h0fff, 1, d);
      chk("write unlocked", d[15:0], 16'hbad0);
   endtask : t_prot
   task automatic t_uid;
      m.frame({8'h0c, 68'hf_ffff_ffff_ffff_ffff}, 76, 100.0, rx, oe);
      chk("identifier", rx[67:4], 64'h2468_ace0_1357_9bdf);
      chk("held bit", rx[3:0], 4'hf);
   endtask : t_uid
   // Eighteen valid opcodes reach the device; the disabled frame and the bad ones do not count.
   task automatic t_end;
      logic [31:0] r;
      logic        e;
      apb(1'b0, `FSC_STATUS_OFS, 32'h0, r, e);
      chk("status", r, 32'h0000_0c00);
      apb(1'b0, `FSC_CMDCNT_OFS, 32'h0, r, e);
      chk("command count", r, 32'h0000_0012);
   endtask : t_end
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (12) @(posedge clock);
      srst <= 1'b0;
      repeat (4) @(posedge clock);
      t_regs();
      t_rw();
      t_bad();
      t_prot();
      t_uid();
      t_end();
      test_done();
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_errors++;
         test_done();
      end
   end
endmodule : fsc_top_bench
